// file: hw/supply_monitor_pkg.sv
// Shared constants and types of the input supply monitor
package supply_monitor_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] FAILSAFE_OFFSET = 8'h04;
  localparam logic [7:0] FS_TIME_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;
  localparam logic [7:0] INT_STATUS_OFFSET = 8'h10;
  localparam logic [7:0] INT_MASK_OFFSET = 8'h14;

  // Control register fields
  localparam int CTRL_OV_EN_BIT = 0;
  localparam int CTRL_OV_SDWN_BIT = 1;
  localparam int CTRL_DBNC_LSB = 2;

  // Status register fields
  localparam int STATUS_STATE_LSB = 0;
  localparam int STATUS_OV_BIT = 3;
  localparam int STATUS_UV_BIT = 4;
  localparam int STATUS_BACKUP_BIT = 5;

  // Interrupt bits, same layout in status and mask
  localparam int INT_OV_BIT = 0;
  localparam int INT_ABORT_BIT = 1;
  localparam int INT_FS_BIT = 2;
  localparam int INT_W = 3;

  // Reset values
  localparam logic RST_OV_EN = 1'b0;
  localparam logic RST_OV_SDWN = 1'b0;
  localparam logic [1:0] RST_OV_DBNC = 2'h0;
  localparam logic [3:0] RST_FAILSAFE_RETRY_COUNT = 4'h0;
  localparam logic [15:0] RST_FS_TIME = 16'h03E8;
  localparam logic [2:0] RST_INT_MASK = 3'h0;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS = 1000;
  localparam int US_TICK_CYCLES =
    (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] US_TICK_LAST = 7'(US_TICK_CYCLES - 1);
  localparam logic [10:0] DBNC_US_00 = 11'h00A;
  localparam logic [10:0] DBNC_US_01 = 11'h064;
  localparam logic [10:0] DBNC_US_10 = 11'h3E8;

  typedef enum logic [2:0] {
    ST_UNPOWERED,
    ST_COIN_CELL,
    ST_FUSE_LOAD,
    ST_OFF,
    ST_POWER_UP,
    ST_SYSTEM_ON,
    ST_POWER_DOWN
  } state_t;

endpackage : supply_monitor_pkg

// file: hw/input_supply_monitor.sv
// Input supply monitor: supply states, overvoltage lockout, fail-safe count
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module input_supply_monitor
  import supply_monitor_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic undervoltage_detect,
  input wire logic coin_cell_input,
  input wire logic input_overvoltage_lockout,
  input wire logic fused_overvoltage_enable,
  input wire logic fused_overvoltage_shutdown,
  input wire logic [1:0] fused_overvoltage_debounce,
  input wire logic [1:0] fused_backup_voltage_select,
  input wire logic [3:0] fused_failsafe_count,
  input wire logic power_on_request,
  input wire logic power_off_request,
  input wire logic power_up_done,
  input wire logic power_down_done,
  output logic fuse_load,
  output logic backup_domain_supply,
  output logic regulators_enable,
  output logic power_down_start,
  output logic power_up_abort,
  output logic irq
);

  typedef struct packed {
    state_t state;
    logic uv_prev;
    logic [6:0] us_div;
    logic [6:0] ov_pre;
    logic [10:0] ov_cnt;
    logic ov_active;
    logic ov_en;
    logic ov_sdwn;
    logic [1:0] ov_dbnc;
    logic [3:0] failsafe_retry_count;
    logic [15:0] fs_time;
    logic [15:0] fs_timer;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_mask;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic hready_out;
    logic [31:0] rdata;
    logic irq;
    logic fuse_load;
    logic backup_en;
    logic reg_en;
    logic pwr_down;
    logic pwr_abort;
  } regs_t;

  regs_t state_reg;
  regs_t state_next;

  // Debounce length in microsecond ticks
  function automatic logic [10:0] dbnc_limit(input logic [1:0] code);
    case (code)
      2'h0: dbnc_limit = DBNC_US_00;
      2'h1: dbnc_limit = DBNC_US_01;
      // Reserved code behaves as the longest setting, the safe side
      default: dbnc_limit = DBNC_US_10;
    endcase
  endfunction : dbnc_limit

  // True once fuses are loaded and the main supply is up
  function automatic logic powered(input state_t s);
    powered = (s == ST_OFF) || (s == ST_POWER_UP) ||
              (s == ST_SYSTEM_ON) || (s == ST_POWER_DOWN);
  endfunction : powered

  function automatic logic [31:0] read_value(input regs_t s,
                                             input logic [7:0] addr);
    read_value = 32'h0000_0000;
    case (addr)
      CTRL_OFFSET:
      begin
        read_value[CTRL_OV_EN_BIT] = s.ov_en;
        read_value[CTRL_OV_SDWN_BIT] = s.ov_sdwn;
        read_value[CTRL_DBNC_LSB +: 2] = s.ov_dbnc;
      end
      FAILSAFE_OFFSET: read_value[3:0] = s.failsafe_retry_count;
      FS_TIME_OFFSET: read_value[15:0] = s.fs_time;
      STATUS_OFFSET:
      begin
        read_value[STATUS_STATE_LSB +: 3] = s.state;
        read_value[STATUS_OV_BIT] = s.ov_active;
        read_value[STATUS_UV_BIT] = s.uv_prev;
        read_value[STATUS_BACKUP_BIT] = s.backup_en;
      end
      INT_STATUS_OFFSET: read_value[INT_W-1:0] = s.int_stat;
      INT_MASK_OFFSET: read_value[INT_W-1:0] = s.int_mask;
      default: read_value = 32'h0000_0000;
    endcase
  endfunction : read_value

  logic uv_rise;
  logic us_tick;
  logic mon_on;
  logic ov_event;
  logic [INT_W-1:0] int_set;
  logic acc;

  always_comb
  begin
    state_next = state_reg;
    int_set = '0;
    ov_event = 1'b0;
    state_next.fuse_load = 1'b0;
    state_next.pwr_down = 1'b0;
    state_next.pwr_abort = 1'b0;
    state_next.hready_out = 1'b1;

    uv_rise = undervoltage_detect & ~state_reg.uv_prev;
    state_next.uv_prev = undervoltage_detect;

    us_tick = (state_reg.us_div == US_TICK_LAST);
    state_next.us_div = us_tick ? 7'h00 : state_reg.us_div + 7'h01;

    // The debounce has its own prescaler, cleared with the count, so the
    // qualification time is exact rather than off by a partial tick
    mon_on = state_reg.ov_en & input_overvoltage_lockout &
             powered(state_reg.state);
    if (!mon_on)
    begin
      state_next.ov_pre = 7'h00;
      state_next.ov_cnt = 11'h000;
      state_next.ov_active = 1'b0;
    end
    else if (!state_reg.ov_active)
    begin
      if (state_reg.ov_pre == US_TICK_LAST)
      begin
        state_next.ov_pre = 7'h00;
        state_next.ov_cnt = state_reg.ov_cnt + 11'h001;
        // At or past the limit, so shortening the setting mid-count still fires
        if (state_reg.ov_cnt + 11'h001 >= dbnc_limit(state_reg.ov_dbnc))
        begin
          state_next.ov_active = 1'b1;
          ov_event = 1'b1;
        end
      end
      else
      begin
        state_next.ov_pre = state_reg.ov_pre + 7'h01;
      end
    end

    // Every qualified overvoltage is reported
    if (ov_event)
    begin
      int_set[INT_OV_BIT] = 1'b1;
    end

    case (state_reg.state)
      ST_UNPOWERED, ST_COIN_CELL:
      begin
        if (uv_rise)
        begin
          state_next.state = ST_FUSE_LOAD;
        end
        else if (!undervoltage_detect && coin_cell_input)
        begin
          state_next.state = ST_COIN_CELL;
        end
        else
        begin
          state_next.state = ST_UNPOWERED;
        end
      end
      ST_FUSE_LOAD:
      begin
        state_next.fuse_load = 1'b1;
        state_next.ov_en = fused_overvoltage_enable;
        state_next.ov_sdwn = fused_overvoltage_shutdown;
        state_next.ov_dbnc = fused_overvoltage_debounce;
        state_next.failsafe_retry_count = fused_failsafe_count;
        state_next.state = ST_OFF;
      end
      ST_OFF:
      begin
        // A standing lockout with shutdown selected blocks power up
        if (power_on_request &&
            !(state_reg.ov_active && state_reg.ov_sdwn))
        begin
          state_next.state = ST_POWER_UP;
        end
      end
      ST_POWER_UP:
      begin
        // The fused setting rules here, not the software copy
        if (ov_event && fused_overvoltage_shutdown)
        begin
          state_next.state = ST_OFF;
          state_next.pwr_abort = 1'b1;
          int_set[INT_ABORT_BIT] = 1'b1;
        end
        else if (power_up_done)
        begin
          state_next.state = ST_SYSTEM_ON;
        end
      end
      ST_SYSTEM_ON:
      begin
        if ((ov_event && state_reg.ov_sdwn) || power_off_request)
        begin
          state_next.state = ST_POWER_DOWN;
          state_next.pwr_down = 1'b1;
        end
      end
      ST_POWER_DOWN:
      begin
        if (power_down_done)
        begin
          state_next.state = ST_OFF;
        end
      end
      default: state_next.state = ST_UNPOWERED;
    endcase

    // Losing the main input wins over the next state chosen in every powered state
    if (!undervoltage_detect && powered(state_reg.state))
    begin
      state_next.state = coin_cell_input ? ST_COIN_CELL : ST_UNPOWERED;
    end

    state_next.backup_en = (state_next.state == ST_COIN_CELL) &&
                           (fused_backup_voltage_select != 2'h0);
    state_next.reg_en = (state_next.state == ST_POWER_UP) ||
                        (state_next.state == ST_SYSTEM_ON);

    // Fail-safe timer in microsecond ticks, only in system-on
    if ((state_reg.state == ST_SYSTEM_ON) && (state_reg.failsafe_retry_count != 4'h0))
    begin
      if (us_tick)
      begin
        if (state_reg.fs_timer + 16'h0001 >= state_reg.fs_time)
        begin
          state_next.fs_timer = 16'h0000;
          state_next.failsafe_retry_count = state_reg.failsafe_retry_count - 4'h1;
          int_set[INT_FS_BIT] = 1'b1;
        end
        else
        begin
          state_next.fs_timer = state_reg.fs_timer + 16'h0001;
        end
      end
    end
    else
    begin
      state_next.fs_timer = 16'h0000;
    end

    // Bus write data phase
    if (state_reg.wr_pend)
    begin
      case (state_reg.wr_addr)
        CTRL_OFFSET:
        begin
          state_next.ov_en = hwdata[CTRL_OV_EN_BIT];
          state_next.ov_sdwn = hwdata[CTRL_OV_SDWN_BIT];
          state_next.ov_dbnc = hwdata[CTRL_DBNC_LSB +: 2];
        end
        FAILSAFE_OFFSET:
        begin
          // A write in system-on clears; software then owns the count
          if (state_reg.state == ST_SYSTEM_ON)
          begin
            state_next.failsafe_retry_count = 4'h0;
            state_next.fs_timer = 16'h0000;
          end
        end
        FS_TIME_OFFSET: state_next.fs_time = hwdata[15:0];
        INT_MASK_OFFSET: state_next.int_mask = hwdata[INT_W-1:0];
        default: state_next.int_mask = state_next.int_mask;
      endcase
    end

    // Bus address phase: reads are answered in the next cycle
    acc = hsel & htrans[1] & hready;
    state_next.wr_pend = acc & hwrite;
    state_next.wr_addr = {haddr[7:2], 2'b00};
    state_next.rdata = 32'h0000_0000;
    if (acc && !hwrite)
    begin
      state_next.rdata = read_value(state_next, {haddr[7:2], 2'b00});
      if ({haddr[7:2], 2'b00} == INT_STATUS_OFFSET)
      begin
        state_next.int_stat = '0;
      end
    end
    // Applied after the read clear so a coincident event survives
    state_next.int_stat = state_next.int_stat | int_set;
    state_next.irq = |(state_next.int_stat & state_next.int_mask);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= '{
        state: ST_UNPOWERED,
        uv_prev: 1'b0,
        us_div: 7'h00,
        ov_pre: 7'h00,
        ov_cnt: 11'h000,
        ov_active: 1'b0,
        ov_en: RST_OV_EN,
        ov_sdwn: RST_OV_SDWN,
        ov_dbnc: RST_OV_DBNC,
        failsafe_retry_count: RST_FAILSAFE_RETRY_COUNT,
        fs_time: RST_FS_TIME,
        fs_timer: 16'h0000,
        int_stat: '0,
        int_mask: RST_INT_MASK,
        wr_pend: 1'b0,
        wr_addr: 8'h00,
        hready_out: 1'b1,
        rdata: 32'h0000_0000,
        irq: 1'b0,
        fuse_load: 1'b0,
        backup_en: 1'b0,
        reg_en: 1'b0,
        pwr_down: 1'b0,
        pwr_abort: 1'b0
      };
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign hreadyout = state_reg.hready_out;
  assign hresp = 1'b0;
  assign hrdata = state_reg.rdata;
  assign fuse_load = state_reg.fuse_load;
  assign backup_domain_supply = state_reg.backup_en;
  assign regulators_enable = state_reg.reg_en;
  assign power_down_start = state_reg.pwr_down;
  assign power_up_abort = state_reg.pwr_abort;
  assign irq = state_reg.irq;

endmodule : input_supply_monitor

// file: sim/supply_monitor_props.sv
// Assertion checker for the input supply monitor ports
`timescale 1ns/1ps
module supply_monitor_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic undervoltage_detect,
  input wire logic input_overvoltage_lockout,
  input wire logic power_off_request,
  input wire logic [1:0] fused_backup_voltage_select,
  input wire logic fuse_load,
  input wire logic backup_domain_supply,
  input wire logic regulators_enable,
  input wire logic power_down_start,
  input wire logic power_up_abort
);
  logic [10:0] ov_run_reg;
  // Saturates so a long overvoltage never wraps back under the limit
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ov_run_reg <= 11'h000;
    else if (!input_overvoltage_lockout)
      ov_run_reg <= 11'h000;
    else if (ov_run_reg != 11'h7FF)
      ov_run_reg <= ov_run_reg + 11'h001;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  AST_FUSE_AFTER_RISE: assert property (fuse_load |->
    $past(undervoltage_detect) && $past(undervoltage_detect, 2))
    else $error("fuse load without undervoltage rise");
  AST_FUSE_PULSE: assert property (fuse_load |=> !fuse_load)
    else $error("fuse load longer than one cycle");
  AST_UV_LOW_OFF: assert property (!undervoltage_detect ##1
    !undervoltage_detect |=> !regulators_enable && !fuse_load)
    else $error("powered while below undervoltage threshold");
  AST_BACKUP_COIN: assert property (backup_domain_supply |->
    !regulators_enable && fused_backup_voltage_select != 2'h0)
    else $error("backup supply on outside coin cell state");
  AST_ABORT_DBNC: assert property (power_up_abort |->
    $past(ov_run_reg) >= 11'h4E1)
    else $error("power up abort before debounce");
  AST_PD_CAUSE: assert property (power_down_start |->
    $past(ov_run_reg) >= 11'h4E1 || $past(power_off_request)
    || $past(power_off_request, 2))
    else $error("power down without a cause");
  AST_ABORT_OFF: assert property (power_up_abort |->
    !regulators_enable ##1 !power_up_abort)
    else $error("abort left regulators on");
endmodule : supply_monitor_props

bind input_supply_monitor supply_monitor_props props (.hclk(hclk),
  .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .undervoltage_detect(undervoltage_detect),
  .input_overvoltage_lockout(input_overvoltage_lockout),
  .power_off_request(power_off_request),
  .fused_backup_voltage_select(fused_backup_voltage_select),
  .fuse_load(fuse_load), .backup_domain_supply(backup_domain_supply),
  .regulators_enable(regulators_enable),
  .power_down_start(power_down_start), .power_up_abort(power_up_abort));

// file: sim/input_supply_monitor_tb_top.sv
// Self-checking testbench of the input supply monitor
`timescale 1ns/1ps
module input_supply_monitor_tb_top;
  import supply_monitor_pkg::*;
  typedef struct {logic [3:0] ctrl; int lim; logic ovi; logic pd;} row_t;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans, fused_overvoltage_debounce, fused_backup_voltage_select;
  logic [2:0] hsize;
  logic [3:0] fused_failsafe_count;
  logic undervoltage_detect, coin_cell_input, input_overvoltage_lockout;
  logic fused_overvoltage_enable, fused_overvoltage_shutdown;
  logic power_on_request, power_off_request, power_up_done;
  logic power_down_done, fuse_load, backup_domain_supply;
  logic regulators_enable, power_down_start, power_up_abort;
  int num_errors = 0;
  int samples_checked = 0;
  int pd_cnt = 0;
  int pua_cnt = 0;
  int fl_cnt = 0;
  int n, p;
  logic in_window;
  row_t rows[4] = '{'{4'h0, 1250, 1'h0, 1'h0}, '{4'h1, 1250, 1'h1, 1'h0},
    '{4'h3, 1250, 1'h1, 1'h1}, '{4'h5, 12500, 1'h1, 1'h0}};
  assign hready = hreadyout;
  input_supply_monitor dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .undervoltage_detect, .coin_cell_input, .input_overvoltage_lockout,
    .fused_overvoltage_enable, .fused_overvoltage_shutdown,
    .fused_overvoltage_debounce, .fused_backup_voltage_select,
    .fused_failsafe_count, .power_on_request, .power_off_request,
    .power_up_done, .power_down_done, .fuse_load, .backup_domain_supply,
    .regulators_enable, .power_down_start, .power_up_abort, .irq);
  initial
  begin
    hclk = 1'h0;
    forever #4 hclk = ~hclk;
  end
  // Pulses are counted so the main sequence can sample them lazily
  always @(posedge hclk)
  begin
    pd_cnt <= pd_cnt + int'(power_down_start);
    pua_cnt <= pua_cnt + int'(power_up_abort);
    fl_cnt <= fl_cnt + int'(fuse_load);
  end
  task automatic tick(input int k);
    repeat (k) @(posedge hclk);
  endtask : tick
  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", s, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'h1);
    r = hrdata;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk($sformatf("register %h", a), e, r & m);
  endtask : rd
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  initial
  begin
    tick(60000);
    num_errors++;
    close_out();
  end
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {undervoltage_detect, coin_cell_input, input_overvoltage_lockout} = '0;
    {power_on_request, power_off_request, power_up_done} = '0;
    power_down_done = 1'h0;
    fused_overvoltage_enable = 1'h1;
    fused_overvoltage_shutdown = 1'h0;
    fused_overvoltage_debounce = 2'h0;
    fused_backup_voltage_select = 2'h1;
    fused_failsafe_count = 4'h2;
    tick(12);
    chk("outputs in reset", 32'h0, {25'h0, hresp, fuse_load,
      backup_domain_supply, regulators_enable, power_down_start,
      power_up_abort, irq});
    chk("read data in reset", 32'h0, hrdata);
    chk("ready in reset", 32'h1, {31'h0, hreadyout});
    hresetn <= 1'h1;
    tick(1);
    rd(CTRL_OFFSET, 32'hF, 32'h0);
    rd(FS_TIME_OFFSET, 32'hFFFF, 32'h3E8);
    rd(INT_MASK_OFFSET, 32'h7, 32'h0);
    rd(8'h20, 32'hFFFFFFFF, 32'h0);
    chk("fuse loads", 32'h0, fl_cnt);
    undervoltage_detect <= 1'h1;
    tick(4);
    chk("fuse loads", 32'h1, fl_cnt);
    rd(CTRL_OFFSET, 32'hF, 32'h1);
    bus(1'h1, INT_MASK_OFFSET, 32'h7);
    bus(1'h1, FS_TIME_OFFSET, 32'h2);
    power_on_request <= 1'h1;
    tick(3);
    rd(STATUS_OFFSET, 32'h7, 32'h4);
    input_overvoltage_lockout <= 1'h1;
    tick(1300);
    chk("power up overvoltage", 32'h3, {irq, regulators_enable});
    chk("aborts", 32'h0, pua_cnt);
    rd(INT_STATUS_OFFSET, 32'h7, 32'h1);
    input_overvoltage_lockout <= 1'h0;
    power_up_done <= 1'h1;
    power_down_done <= 1'h1;
    tick(100);
    rd(FAILSAFE_OFFSET, 32'hF, 32'h2);
    tick(250);
    rd(FAILSAFE_OFFSET, 32'hF, 32'h1);
    bus(1'h1, FAILSAFE_OFFSET, 32'h0);
    rd(FAILSAFE_OFFSET, 32'hF, 32'h0);
    tick(600);
    rd(FAILSAFE_OFFSET, 32'hF, 32'h0);
    rd(INT_STATUS_OFFSET, 32'h7, 32'h4);
    foreach (rows[i])
    begin
      bus(1'h1, CTRL_OFFSET, {28'h0, rows[i].ctrl});
      p = pd_cnt;
      input_overvoltage_lockout <= 1'h1;
      tick(rows[i].lim - 20);
      input_overvoltage_lockout <= 1'h0;
      tick(1);
      input_overvoltage_lockout <= 1'h1;
      n = 0;
      while (irq !== 1'h1 && n < rows[i].lim + 20)
      begin
        tick(1);
        n++;
      end
      in_window = n >= rows[i].lim && n <= rows[i].lim + 4;
      chk("debounce", rows[i].ovi, in_window);
      input_overvoltage_lockout <= 1'h0;
      tick(8);
      chk("power downs", rows[i].pd, pd_cnt - p);
      rd(INT_STATUS_OFFSET, 32'h7, rows[i].ovi);
      rd(STATUS_OFFSET, 32'h7, 32'h5);
    end
    // Software power off request takes the same power down path
    p = pd_cnt;
    power_off_request <= 1'h1;
    tick(1);
    power_off_request <= 1'h0;
    tick(6);
    chk("power off request", 32'h1, pd_cnt - p);
    rd(STATUS_OFFSET, 32'h7, 32'h5);
    undervoltage_detect <= 1'h0;
    tick(3);
    rd(STATUS_OFFSET, 32'h27, 32'h0);
    coin_cell_input <= 1'h1;
    tick(3);
    rd(STATUS_OFFSET, 32'h7, 32'h1);
    chk("backup supply", 32'h1, backup_domain_supply);
    fused_overvoltage_shutdown <= 1'h1;
    power_up_done <= 1'h0;
    undervoltage_detect <= 1'h1;
    tick(6);
    rd(CTRL_OFFSET, 32'hF, 32'h3);
    rd(STATUS_OFFSET, 32'h7, 32'h4);
    input_overvoltage_lockout <= 1'h1;
    tick(1400);
    chk("aborts", 32'h1, pua_cnt);
    chk("regulators", 32'h0, regulators_enable);
    rd(STATUS_OFFSET, 32'h7, 32'h3);
    close_out();
  end
endmodule : input_supply_monitor_tb_top
